// [logic/cfps_core.sv]
// fetch/execute pipeline, return stack flags and shadow store
//
// Functional notes
// - fault with reset enable: flag, then reset
// - fault without reset enable: flag only
// - stack flags sticky until software or power-on
// - one-deep shadow store, not software visible
// - interrupt vectoring captures status, w, bank
// - fast interrupt return restores; plain does not
// - high interrupt overwrites low entry's shadow
// - fast call saves, fast return restores
// - clock divided into four quadrature phases
// - pc advances phase one, fetch captured four
// - four phases; execute in following cycle
// - fetch overlaps execute, one per cycle
// - pc change takes two cycles, flushes
// - operand read phase two, write phase four
// - table read moves one byte per operation
// - pc low write loads high/upper latches
// - overflow reset keeps full, clears pointer
// - empty pop: pc zero, underflow, pointer zero
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "cfps_params.svh"
module cfps_core (
   // clock and power-on reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // program memory fetch port
   output logic [20:0]      pm_addr,
   output logic             pm_rd_en,
   input  wire logic [15:0] pm_rdata,
   // program memory table byte port
   output logic [20:0]      tbl_addr,
   output logic             tbl_rd_en,
   input  wire logic [7:0]  tbl_rdata,
   // data memory port
   output logic [11:0]      dm_addr,
   output logic             dm_rd_en,
   output logic             dm_wr_en,
   output logic [7:0]       dm_wdata,
   input  wire logic [7:0]  dm_rdata,
   // interrupt request pins
   input  wire logic        irq_high,
   input  wire logic        irq_low,
   // status out
   output logic [3:0]       phase_en,
   output logic             stack_reset
);
   cfps_pkg::cfps_core_t r;
   cfps_pkg::cfps_core_t n;
   cfps_pkg::cfps_op_t   op;
   logic [3:0]           q;
   logic                 ex;
   logic                 fast;
   logic [7:0]           k;
   logic                 jump;
   logic                 push;
   logic                 pop;
   logic                 take_h;
   logic                 take_l;
   logic                 rst;
   logic [20:0]          target;
   logic [8:0]           sum;
   logic                 setup;
   logic                 wr;

   // quadrature phase source
   cfps_phase_gen u_phase (
      .pclk     (pclk),
      .presetn  (presetn),
      .phase_en (q)
   );

   // instruction fields; a flushed slot executes nothing
   assign op    = cfps_pkg::cfps_op_t'(r.ir[15:12]);
   assign ex    = r.ir_valid;
   assign fast  = r.ir[11];
   assign k     = r.ir[7:0];
   assign setup = psel && !penable;
   assign wr    = psel && penable && r.pready && pwrite;

   // next state of the whole core
   always_comb begin
      n = r;
      jump   = 1'b0;
      push   = 1'b0;
      pop    = 1'b0;
      take_h = 1'b0;
      take_l = 1'b0;
      rst    = 1'b0;
      target = 21'h0;
      sum    = 9'h0;
      n.dev_rst = 1'b0;
      // two-stage synchronisers on the request pins
      n.irqh_m = irq_high;
      n.irqh   = r.irqh_m;
      n.irql_m = irq_low;
      n.irql   = r.irql_m;
      // apb: answer one cycle after setup
      n.pready  = setup;
      n.pslverr = 1'b0;
      if (setup) begin
         unique case (paddr)
            `CFPS_ADDR_CTRL:
               n.prdata = {29'h0, r.giel, r.gieh, r.sfre};
            `CFPS_ADDR_STACK:
               n.prdata = {24'h0, r.full, r.unf, 1'b0, r.sp};
            `CFPS_ADDR_CORE:
               n.prdata = {11'h0, r.status, 4'h0, r.bank_select_register, r.w};
            `CFPS_ADDR_PC:
               n.prdata = {11'h0, r.pc};
            `CFPS_ADDR_LATCH:
               n.prdata = {19'h0, r.latch_u, r.latch_h};
            `CFPS_ADDR_TABLE:
               n.prdata = {r.table_latch_data, 3'h0, r.table_pointer};
            default: begin
               n.prdata  = 32'h0;
               n.pslverr = 1'b1;
            end
         endcase
      end
      // apb writes; hardware events below win over them
      if (wr) begin
         unique case (paddr)
            `CFPS_ADDR_CTRL: begin
               n.sfre = pwdata[`CFPS_CTRL_SFRE];
               n.gieh = pwdata[`CFPS_CTRL_GIEH];
               n.giel = pwdata[`CFPS_CTRL_GIEL];
            end
            `CFPS_ADDR_STACK: begin
               // flags clear by writing zero only
               if (!pwdata[`CFPS_STK_FULL])
                  n.full = 1'b0;
               if (!pwdata[`CFPS_STK_UNF])
                  n.unf = 1'b0;
               n.sp = pwdata[4:0];
            end
            `CFPS_ADDR_LATCH: begin
               n.latch_h = pwdata[7:0];
               n.latch_u = pwdata[12:8];
            end
            `CFPS_ADDR_TABLE: n.table_pointer = pwdata[20:0];
            default: ;
         endcase
      end
      // phase one: fetch next word, operand and table reads
      if (q[0]) begin
         n.fetch_addr = r.pc;
         n.pc         = r.pc + `CFPS_PC_STEP;
         n.pm_rd_en   = 1'b1;
         n.dm_addr    = {r.bank_select_register, k};
         n.dm_rd_en   = ex && (op == cfps_pkg::CFPS_OP_MOVF);
         n.tbl_rd_en  = ex && (op == cfps_pkg::CFPS_OP_TBLRD);
      end
      // phase two: operand and table byte arrive
      if (q[1]) begin
         n.dm_rd_en = 1'b0;
         if (r.dm_rd_en)
            n.operand = dm_rdata;
         if (r.tbl_rd_en)
            n.table_latch_data = tbl_rdata;
         n.tbl_rd_en = 1'b0;
      end
      // phase three: present destination write for phase four
      if (q[2] && ex && (op == cfps_pkg::CFPS_OP_MOVWF)) begin
         n.dm_addr  = {r.bank_select_register, k};
         n.dm_wdata = r.w;
         n.dm_wr_en = 1'b1;
      end
      // phase four: finish execute, capture fetched word
      if (q[3]) begin
         n.dm_wr_en = 1'b0;
         n.pm_rd_en = 1'b0;
         n.ir       = pm_rdata;
         n.ir_valid = 1'b1;
         if (ex) begin
            unique case (op)
               cfps_pkg::CFPS_OP_MOVLW: n.w = k;
               cfps_pkg::CFPS_OP_MOVLB: n.bank_select_register = k[3:0];
               cfps_pkg::CFPS_OP_MOVF: begin
                  n.w = r.operand;
                  n.status[`CFPS_ST_ZERO] = (r.operand == 8'h0);
                  n.status[`CFPS_ST_NEG]  = r.operand[7];
               end
               cfps_pkg::CFPS_OP_ADDWPC: begin
                  // low byte of pc plus w; offset kept even
                  sum = {1'b0, r.fetch_addr[7:0]} + {1'b0, r.w};
                  target = {r.latch_u, r.latch_h,
                            sum[7:1], 1'b0};
                  n.status[`CFPS_ST_CARRY] = sum[8];
                  n.status[`CFPS_ST_ZERO]  = (sum[7:0] == 8'h0);
                  jump = 1'b1;
               end
               cfps_pkg::CFPS_OP_GOTO: begin
                  target = {9'h0, r.ir[10:0], 1'b0};
                  jump   = 1'b1;
               end
               cfps_pkg::CFPS_OP_CALL: begin
                  target = {9'h0, r.ir[10:0], 1'b0};
                  jump   = 1'b1;
                  push   = 1'b1;
               end
               cfps_pkg::CFPS_OP_RET,
               cfps_pkg::CFPS_OP_RETI,
               cfps_pkg::CFPS_OP_RETK: begin
                  jump = 1'b1;
                  pop  = 1'b1;
               end
               default: ;
            endcase
            // fast return restores the shadow store
            if (fast && (op == cfps_pkg::CFPS_OP_RET ||
                         op == cfps_pkg::CFPS_OP_RETI)) begin
               n.w      = r.sh_w;
               n.bank_select_register    = r.sh_bsr;
               n.status = r.sh_status;
            end
            if (op == cfps_pkg::CFPS_OP_RETK)
               n.w = k;
            // interrupt return reopens the level that was closed
            if (op == cfps_pkg::CFPS_OP_RETI) begin
               if (!r.gieh)
                  n.gieh = 1'b1;
               else
                  n.giel = 1'b1;
            end
            // fast call saves into the shadow store
            if (fast && op == cfps_pkg::CFPS_OP_CALL) begin
               n.sh_w      = r.w;
               n.sh_bsr    = r.bank_select_register;
               n.sh_status = r.status;
            end
         end
         // interrupt vectoring in place of a sequential step
         if (!jump) begin
            take_h = r.irqh && r.gieh;
            take_l = !take_h && r.irql && r.gieh && r.giel;
         end
         if (take_h || take_l) begin
            target = take_h ? `CFPS_VEC_HIGH : `CFPS_VEC_LOW;
            jump   = 1'b1;
            push   = 1'b1;
            // shadow overwritten by every vectoring
            n.sh_w      = n.w;
            n.sh_bsr    = n.bank_select_register;
            n.sh_status = n.status;
            if (take_h)
               n.gieh = 1'b0;
            else
               n.giel = 1'b0;
         end
         // push of the address after the current word
         if (push) begin
            if (r.sp == `CFPS_SP_TOP) begin
               n.full = 1'b1;
               rst    = r.sfre;
            end else begin
               n.sp = r.sp + 5'h1;
               n.stk[r.sp + 5'h1] = r.fetch_addr;
               if (r.sp + 5'h1 == `CFPS_SP_TOP) begin
                  n.full = 1'b1;
                  rst    = r.sfre;
               end
            end
         end
         // pop; an empty stack returns zero
         if (pop) begin
            if (r.sp == 5'h0) begin
               target = 21'h0;
               n.unf  = 1'b1;
               rst    = r.sfre;
            end else begin
               target = r.stk[r.sp];
               n.sp   = r.sp - 5'h1;
            end
         end
         // pc change drops the word fetched this cycle
         if (jump) begin
            n.pc       = target;
            n.ir_valid = 1'b0;
         end
         // stack fault reset: flags stay, pointer cleared
         if (rst) begin
            n.pc       = 21'h0;
            n.sp       = 5'h0;
            n.ir_valid = 1'b0;
            n.gieh     = 1'b0;
            n.giel     = 1'b0;
            n.dev_rst  = 1'b1;
         end
      end
   end

   // state register; async reset acts as power-on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r      <= '0;
         r.sfre <= `CFPS_SFRE_RST;
      end else begin
         r <= n;
      end
   end

   // outputs straight from the state flops
   assign prdata      = r.prdata;
   assign pready      = r.pready;
   assign pslverr     = r.pslverr;
   assign pm_addr     = r.fetch_addr;
   assign pm_rd_en    = r.pm_rd_en;
   assign tbl_addr    = r.table_pointer;
   assign tbl_rd_en   = r.tbl_rd_en;
   assign dm_addr     = r.dm_addr;
   assign dm_rd_en    = r.dm_rd_en;
   assign dm_wr_en    = r.dm_wr_en;
   assign dm_wdata    = r.dm_wdata;
   assign phase_en    = q;
   assign stack_reset = r.dev_rst;
endmodule : cfps_core

// [logic/cfps_params.svh]
// constants of the fetch pipeline and stack core
`ifndef CFPS_PARAMS_SVH
`define CFPS_PARAMS_SVH
// register byte offsets
`define CFPS_ADDR_CTRL  12'h000
`define CFPS_ADDR_STACK 12'h004
`define CFPS_ADDR_CORE  12'h008
`define CFPS_ADDR_PC    12'h00c
`define CFPS_ADDR_LATCH 12'h010
`define CFPS_ADDR_TABLE 12'h014
// field positions
`define CFPS_CTRL_SFRE   0
`define CFPS_CTRL_GIEH   1
`define CFPS_CTRL_GIEL   2
`define CFPS_STK_FULL    7
`define CFPS_STK_UNF     6
`define CFPS_ST_CARRY    0
`define CFPS_ST_ZERO     2
`define CFPS_ST_NEG      4
// reset values and fixed addresses
`define CFPS_SFRE_RST    1'b1
`define CFPS_SP_TOP      5'h1f
`define CFPS_PC_STEP     21'h000002
`define CFPS_VEC_HIGH    21'h000008
`define CFPS_VEC_LOW     21'h000018
`define CFPS_PHASES      4
`endif

// [logic/cfps_pkg.sv]
// types of the fetch pipeline and stack core
package cfps_pkg;
   // own instruction classes, held in ir[15:12]
   typedef enum logic [3:0] {
      CFPS_OP_NOP    = 4'h0,
      CFPS_OP_MOVLW  = 4'h1,
      CFPS_OP_MOVWF  = 4'h2,
      CFPS_OP_MOVF   = 4'h3,
      CFPS_OP_ADDWPC = 4'h4,
      CFPS_OP_GOTO   = 4'h5,
      CFPS_OP_CALL   = 4'h6,
      CFPS_OP_RET    = 4'h7,
      CFPS_OP_RETI   = 4'h8,
      CFPS_OP_RETK   = 4'h9,
      CFPS_OP_MOVLB  = 4'ha,
      CFPS_OP_TBLRD  = 4'hb
   } cfps_op_t;
   // quadrature phases, gray coded
   typedef enum logic [1:0] {
      CFPS_Q1 = 2'b00,
      CFPS_Q2 = 2'b01,
      CFPS_Q3 = 2'b11,
      CFPS_Q4 = 2'b10
   } cfps_phase_t;
   typedef struct packed {
      cfps_phase_t ph;
      logic [3:0]  en;
   } cfps_pgen_t;
   typedef struct packed {
      logic [20:0]       pc;
      logic [20:0]       fetch_addr;
      logic              pm_rd_en;
      logic [15:0]       ir;
      logic              ir_valid;
      logic [7:0]        w;
      logic [3:0]        bank_select_register;
      logic [4:0]        status;
      logic [7:0]        sh_w;
      logic [3:0]        sh_bsr;
      logic [4:0]        sh_status;
      logic [4:0]        sp;
      logic              full;
      logic              unf;
      logic [31:0][20:0] stk;
      logic              sfre;
      logic              gieh;
      logic              giel;
      logic [7:0]        latch_h;
      logic [4:0]        latch_u;
      logic [20:0]       table_pointer;
      logic [7:0]        table_latch_data;
      logic              tbl_rd_en;
      logic [11:0]       dm_addr;
      logic              dm_rd_en;
      logic              dm_wr_en;
      logic [7:0]        dm_wdata;
      logic [7:0]        operand;
      logic              dev_rst;
      logic              irqh_m;
      logic              irqh;
      logic              irql_m;
      logic              irql;
      logic [31:0]       prdata;
      logic              pready;
      logic              pslverr;
   } cfps_core_t;
endpackage : cfps_pkg

// [logic/cfps_phase_gen.sv]
// divide by four into one-hot quadrature phase enables
`timescale 1ns/100ps
module cfps_phase_gen (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // phase enables, bit 0 is phase one
   output logic [3:0]      phase_en
);
   cfps_pkg::cfps_pgen_t r;
   cfps_pkg::cfps_pgen_t n;

   // advance one phase per clock along the gray path
   always_comb begin
      n = r;
      unique case (r.ph)
         cfps_pkg::CFPS_Q1: begin
            n.ph = cfps_pkg::CFPS_Q2;
            n.en = 4'h2;
         end
         cfps_pkg::CFPS_Q2: begin
            n.ph = cfps_pkg::CFPS_Q3;
            n.en = 4'h4;
         end
         cfps_pkg::CFPS_Q3: begin
            n.ph = cfps_pkg::CFPS_Q4;
            n.en = 4'h8;
         end
         cfps_pkg::CFPS_Q4: begin
            n.ph = cfps_pkg::CFPS_Q1;
            n.en = 4'h1;
         end
      endcase
   end

   // state register, phase one after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r.ph <= cfps_pkg::CFPS_Q1;
         r.en <= 4'h1;
      end else begin
         r <= n;
      end
   end

   assign phase_en = r.en;
endmodule : cfps_phase_gen

// [tb/cfps_props.sv]
// port assertions for the fetch pipeline and stack core
`timescale 1ns/100ps
module cfps_props (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb handshake
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   // memory strobes
   input wire logic [20:0] pm_addr,
   input wire logic        pm_rd_en,
   input wire logic        tbl_rd_en,
   input wire logic        dm_rd_en,
   input wire logic        dm_wr_en,
   // phases and fault reset
   input wire logic [3:0]  phase_en,
   input wire logic        stack_reset
);
   // one clock, checks off during reset
   default clocking ck @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   phase_onehot_a: assert property ($onehot(phase_en))
      else $error("phase not one-hot");
   phase_order_a: assert property (
      phase_en[0] |=> phase_en[1] ##1 phase_en[2] ##1 phase_en[3]
      ##1 phase_en[0])
      else $error("phase order broken");
   fetch_step_a: assert property (
      $changed(pm_addr) |-> $past(phase_en[0]) || $past(stack_reset))
      else $error("fetch address moved off phase one");
   fetch_window_a: assert property (
      pm_rd_en == !phase_en[0])
      else $error("fetch strobe off phases two to four");
   operand_read_a: assert property (
      dm_rd_en |-> phase_en[1] && !dm_wr_en)
      else $error("data read off phase two");
   result_write_a: assert property (
      dm_wr_en |-> phase_en[3])
      else $error("data write off phase four");
   table_byte_a: assert property (tbl_rd_en |-> phase_en[1])
      else $error("table read off phase two");
   apb_answer_a: assert property (
      pready |-> psel && penable && $past(psel && !penable))
      else $error("ready outside access phase");
   fault_pulse_a: assert property (stack_reset |=> !stack_reset)
      else $error("fault reset too long");
endmodule : cfps_props

// [tb/cfps_mem_model.sv]
// program and data memory model beside the core
`timescale 1ns/100ps
module cfps_mem_model (
   // clock
   input wire logic        pclk,
   // fetch and table ports
   input wire logic [20:0] pm_addr,
   input wire logic        pm_rd_en,
   output logic [15:0]     pm_rdata,
   input wire logic [20:0] tbl_addr,
   input wire logic        tbl_rd_en,
   output logic [7:0]      tbl_rdata,
   // data port
   input wire logic [11:0] dm_addr,
   input wire logic        dm_rd_en,
   input wire logic        dm_wr_en,
   input wire logic [7:0]  dm_wdata,
   output logic [7:0]      dm_rdata
);
   logic [15:0] prog [0:1023];
   logic [7:0]  data [0:4095];
   logic [7:0]  junk = 8'ha5;
   logic [15:0] tw;
   // unselected ports show a pattern that flips every cycle
   assign tw = prog[tbl_addr[10:1]];
   assign pm_rdata = pm_rd_en ? prog[pm_addr[10:1]] : {junk, ~junk};
   assign tbl_rdata = !tbl_rd_en ? junk :
                      tbl_addr[0] ? tw[15:8] : tw[7:0];
   assign dm_rdata = dm_rd_en ? data[dm_addr] : ~junk;
   // byte writes land at the phase-four edge
   always @(posedge pclk) begin
      junk <= ~junk;
      if (dm_wr_en) begin
         data[dm_addr] <= dm_wdata;
      end
   end
endmodule : cfps_mem_model

// [tb/cfps_core_bench.sv]
// self-checking bench for the fetch pipeline and stack core
`timescale 1ns/100ps
`include "cfps_params.svh"
module cfps_core_bench;
   localparam logic [3:0] LW = cfps_pkg::CFPS_OP_MOVLW;
   localparam logic [3:0] WF = cfps_pkg::CFPS_OP_MOVWF;
   localparam logic [3:0] FW = cfps_pkg::CFPS_OP_MOVF;
   localparam logic [3:0] AP = cfps_pkg::CFPS_OP_ADDWPC;
   localparam logic [3:0] GO = cfps_pkg::CFPS_OP_GOTO;
   localparam logic [3:0] CA = cfps_pkg::CFPS_OP_CALL;
   localparam logic [3:0] RT = cfps_pkg::CFPS_OP_RET;
   localparam logic [3:0] RI = cfps_pkg::CFPS_OP_RETI;
   localparam logic [3:0] LB = cfps_pkg::CFPS_OP_MOVLB;
   localparam logic [3:0] TR = cfps_pkg::CFPS_OP_TBLRD;
   // stimulus
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        irq_high = 1'b0;
   logic        irq_low = 1'b0;
   // design outputs and bench state
   logic [31:0] prdata, rd;
   logic [20:0] pm_addr, tbl_addr;
   logic [15:0] pm_rdata;
   logic [11:0] dm_addr;
   logic [7:0]  tbl_rdata, dm_wdata, dm_rdata;
   logic [3:0]  phase_en;
   logic        pready, pslverr, err, pm_rd_en, tbl_rd_en;
   logic        dm_rd_en, dm_wr_en, stack_reset;
   int          fails = 0;
   int          comparisons = 0;
   int          pulses = 0;
   int          p0, n;
   // clock and fault reset pulse count
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (stack_reset === 1'b1) begin
         pulses <= pulses + 1;
      end
   end
   // design and its memories
   cfps_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .pm_addr, .pm_rd_en, .pm_rdata,
      .tbl_addr, .tbl_rd_en, .tbl_rdata, .dm_addr, .dm_rd_en, .dm_wr_en,
      .dm_wdata, .dm_rdata, .irq_high, .irq_low, .phase_en, .stack_reset);
   cfps_mem_model mem_u (.pclk, .pm_addr, .pm_rd_en, .pm_rdata, .tbl_addr,
      .tbl_rd_en, .tbl_rdata, .dm_addr, .dm_rd_en, .dm_wr_en, .dm_wdata,
      .dm_rdata);
   // verdict and end of run
   task automatic end_sim;
      if (fails == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   // one counted comparison
   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask : chk
   // one apb transfer, answer left in rd and err
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int k = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // ready, data and error are taken at the same rising edge
      @(posedge pclk);
      while (pready !== 1'b1) begin
         k++;
         if (k > 20) begin
            fails++;
            end_sim();
         end
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // read a register and compare the masked bits
   task automatic reg_is(input string nm, input logic [11:0] a,
                         input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, rd & m);
   endtask : reg_is
   // place one word: byte address, class, fast bit, operand
   task automatic put(input int a, input logic [3:0] op, input logic f,
                      input logic [10:0] v);
      mem_u.prog[a / 2] = {op, f, v};
   endtask : put
   // hold reset and fill program memory with no-ops
   task automatic prep;
      presetn <= 1'b0;
      for (int i = 0; i < 1024; i++) begin
         mem_u.prog[i] = {cfps_pkg::CFPS_OP_NOP, 12'h000};
      end
   endtask : prep
   // release reset after c edges
   task automatic go(input int c);
      repeat (c) @(posedge pclk);
      presetn <= 1'b1;
   endtask : go
   // scenarios
   initial begin
      prep();
      put(0, LB, 1'b0, 11'h003);
      put(2, LW, 1'b0, 11'h05a);
      put(4, WF, 1'b0, 11'h010);
      put(6, LW, 1'b0, 11'h000);
      put(8, FW, 1'b0, 11'h010);
      put(10, TR, 1'b0, 11'h000);
      put(12, GO, 1'b0, 11'h006);
      mem_u.prog[16] = 16'hbe3c;
      go(6);
      reg_is("ctrl", `CFPS_ADDR_CTRL, 32'h7, 32'h1);
      apb(1'b1, `CFPS_ADDR_TABLE, 32'h21);
      repeat (60) @(posedge pclk);
      reg_is("core", `CFPS_ADDR_CORE, 32'hfff, 32'h35a);
      reg_is("latch", `CFPS_ADDR_TABLE,
             32'hff000000, 32'hbe000000);
      chk("mem", 32'h5a, {24'h0, mem_u.data[12'h310]});
      apb(1'b0, 12'h0fc, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      // computed jump through the pc low byte
      prep();
      put(0, LW, 1'b0, 11'h004);
      put(2, AP, 1'b0, 11'h000);
      put(4, LW, 1'b0, 11'h011);
      put(6, LW, 1'b0, 11'h022);
      put(8, LB, 1'b0, 11'h007);
      put('h108, LB, 1'b0, 11'h005);
      put('h10a, GO, 1'b0, 11'h085);
      go(2);
      apb(1'b1, `CFPS_ADDR_LATCH, 32'h1);
      repeat (60) @(posedge pclk);
      reg_is("jump", `CFPS_ADDR_CORE, 32'hfff, 32'h504);
      for (int f = 0; f < 2; f++) begin
         // call and return, plain then fast
         prep();
         put(0, LW, 1'b0, 11'h033);
         put(2, LB, 1'b0, 11'h002);
         put(4, CA, f[0], 11'h010);
         put(6, GO, 1'b0, 11'h003);
         put('h20, LW, 1'b0, 11'h044);
         put('h22, LB, 1'b0, 11'h009);
         put('h24, RT, f[0], 11'h000);
         go(2);
         repeat (80) @(posedge pclk);
         reg_is("call", `CFPS_ADDR_CORE, 32'hfff,
                f ? 32'h233 : 32'h944);
         // interrupt entry and return, plain then fast
         prep();
         put(0, GO, 1'b0, 11'h010);
         put(8, LW, 1'b0, 11'h077);
         put('ha, LB, 1'b0, 11'h008);
         put('hc, RI, f[0], 11'h000);
         put('h20, LW, 1'b0, 11'h066);
         put('h22, LB, 1'b0, 11'h001);
         put('h24, GO, 1'b0, 11'h012);
         put('h26, GO, 1'b0, 11'h012);
         go(2);
         apb(1'b1, `CFPS_ADDR_CTRL, 32'h3);
         repeat (20) @(posedge pclk);
         irq_high <= 1'b1;
         repeat (12) @(posedge pclk);
         irq_high <= 1'b0;
         repeat (60) @(posedge pclk);
         reg_is("irq", `CFPS_ADDR_CORE, 32'hfff,
                f ? 32'h166 : 32'h877);
      end
      for (int e = 0; e < 2; e++) begin
         // return from an empty stack
         prep();
         put(0, LW, 1'b0, 11'h012);
         put(2, RT, 1'b0, 11'h000);
         go(2);
         apb(1'b1, `CFPS_ADDR_CTRL, 32'(e));
         p0 = pulses;
         repeat (40) @(posedge pclk);
         put(0, GO, 1'b0, 11'h000);
         repeat (20) @(posedge pclk);
         chk("unf reset", 32'(e), 32'(pulses != p0));
         reg_is("unf", `CFPS_ADDR_STACK, 32'hff, 32'h40);
         reg_is("w kept", `CFPS_ADDR_CORE, 32'hff, 32'h12);
         apb(1'b1, `CFPS_ADDR_STACK, 32'h0);
         reg_is("clear", `CFPS_ADDR_STACK, 32'hff, 32'h0);
         // calls until the stack is full
         prep();
         put(0, CA, 1'b0, 11'h000);
         go(2);
         apb(1'b1, `CFPS_ADDR_CTRL, 32'(e));
         p0 = pulses;
         n = 0;
         while (n < 400 && !(e == 1 && stack_reset === 1'b1)) begin
            @(negedge pclk);
            n++;
         end
         // a fault reset that never comes is a hang
         if (e == 1 && n >= 400) begin
            fails++;
            end_sim();
         end
         @(posedge pclk);
         reg_is("full", `CFPS_ADDR_STACK, 32'hff,
                e ? 32'h80 : 32'h9f);
         chk("full reset", 32'(e), 32'(pulses != p0));
      end
      end_sim();
   end
endmodule : cfps_core_bench
bind cfps_core cfps_props props_u (.pclk, .presetn, .psel, .penable,
   .pready, .pm_addr, .pm_rd_en, .tbl_rd_en, .dm_rd_en, .dm_wr_en,
   .phase_en, .stack_reset);
